// ==== fault_mon_pkg.sv ====
// Overview of operation
// - In normal state only report faults; act alone on lockout, low supply, undervoltage, overtemperature.
// - After lockout power-on reset, come up with reset flag and error flag set.
// - Clear-reset command clears reset flag; clear-fault command clears error flag.
// - Low supply pulses fault pin 50 us once, latches low-supply and error flags.
// - Low supply disables open and single-LED short diagnosis; recovery re-enables both.
// - Low-supply threshold spans 4 V to 35 V in 1 V steps.
// - Undervoltage sinks fault pin steadily, latches flags, disables outputs until recovery.
// - Reference fault sinks fault pin steadily, latches flags, leaves outputs alone.
// - Reference recovery releases pin; flags stay until clear-fault command.
// - Thermal warning pulses fault pin 50 us, latches warning and error flags.
// - First-level overtemperature turns outputs off, sinks pin, latches flags.
// - Overtemperature recovery resumes outputs, releases pin; flags stay latched.
// - Thermal shutdown sinks pin, sets reset and error flags, restarts from defaults.
// - After shutdown recovery, clear-reset command clears reset and error flags.
// - Watchdog restarts on good addressed non-broadcast frames only.
// - Watchdog overflow enters fail-safe state chosen by the select input.
// - Four-bit period; all ones enters fail-safe directly, zero disables watchdog.
// - Open monitoring only during PWM-on time, longer than blanking interval.
// - Open persisting past blanking with supply good pulses pin, sets channel flags.
package fault_mon_pkg;

    localparam int CLK_HZ            = 10_000_000;
    localparam int NUM_CH            = 24;

    // Fault pulse length
    localparam int PULSE_TIME_US     = 50;
    localparam int PULSE_CYCLES      = (PULSE_TIME_US * CLK_HZ) / 1_000_000;
    localparam int PULSE_CNT_W       = 10;

    // Blanking step of the 4-bit blanking field
    localparam int BLANK_STEP_US     = 1;
    localparam int BLANK_STEP_CYCLES = (BLANK_STEP_US * CLK_HZ) / 1_000_000;
    localparam int BLANK_CNT_W       = 8;

    // Watchdog step of the 4-bit period field
    localparam int WDOG_STEP_US      = 1000;
    localparam int WDOG_STEP_CYCLES  = (WDOG_STEP_US * CLK_HZ) / 1_000_000;
    localparam int WDOG_PRE_W        = 16;
    localparam logic [3:0] WDOG_OFF    = 4'h0;
    localparam logic [3:0] WDOG_DIRECT = 4'hF;

    // Low-supply threshold: volts = code * step + minimum
    localparam logic [5:0] LOW_SUPPLY_MIN_V  = 6'h04;
    localparam logic [5:0] LOW_SUPPLY_STEP_V = 6'h01;
    localparam logic [5:0] LOW_SUPPLY_MAX_V  = 6'h23;

    // Positions in the synchroniser vector
    localparam int SYN_LOWVS = 0;
    localparam int SYN_UV    = 1;
    localparam int SYN_REF   = 2;
    localparam int SYN_TWARN = 3;
    localparam int SYN_TPROT = 4;
    localparam int SYN_TSD   = 5;
    localparam int SYN_FSSEL = 6;
    localparam int SYN_OPEN  = 7;
    localparam int SYN_W     = SYN_OPEN + NUM_CH;

    typedef enum logic [2:0] {
        ST_NORMAL   = 3'b001,
        ST_SHUTDOWN = 3'b010,
        ST_FAILSAFE = 3'b100
    } mon_state_t;

    function automatic logic [BLANK_CNT_W-1:0] blank_limit(input logic [3:0] code);
        blank_limit = BLANK_CNT_W'((code + 5'h01) * BLANK_STEP_CYCLES);
    endfunction : blank_limit

endpackage : fault_mon_pkg

// ==== fault_pulse_timer.sv ====
`timescale 1ns/1ps
module fault_pulse_timer
    import fault_mon_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    // Trigger and running indication
    input  wire logic trig_i,
    output logic      busy_o
);
    typedef struct packed {
        logic [PULSE_CNT_W-1:0] cnt;
        logic                   busy;
    } pulse_t;

    pulse_t r_reg;
    pulse_t r_next;

    // A new trigger restarts the full length
    always_comb begin
        r_next = r_reg;
        if (trig_i) begin
            r_next.cnt = PULSE_CNT_W'(PULSE_CYCLES - 1);
            r_next.busy = 1'b1;
        end else if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end else begin
            r_next.busy = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign busy_o = r_reg.busy;

endmodule : fault_pulse_timer

// ==== comm_watchdog.sv ====
`timescale 1ns/1ps
module comm_watchdog
    import fault_mon_pkg::*;
#(
    parameter int STEP_CYCLES = WDOG_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [3:0] watchdog_period_field_i,
    input  wire logic       kick_i,
    // Expiry
    output logic            overflow_o
);
    typedef struct packed {
        logic [WDOG_PRE_W-1:0] pre;
        logic [3:0]            steps;
        logic                  overflow;
    } wdog_t;

    wdog_t r_reg;
    wdog_t r_next;

    always_comb begin
        r_next = r_reg;
        r_next.overflow = 1'b0;
        if (!run_i || watchdog_period_field_i == WDOG_OFF) begin
            r_next.pre = '0;
            r_next.steps = '0;
        end else if (watchdog_period_field_i == WDOG_DIRECT) begin
            r_next.overflow = 1'b1;
        end else if (kick_i) begin
            r_next.pre = '0;
            r_next.steps = '0;
        end else if (r_reg.pre == WDOG_PRE_W'(STEP_CYCLES - 1)) begin
            // One-cycle step enable from the prescaler
            r_next.pre = '0;
            if (r_reg.steps + 4'h1 >= watchdog_period_field_i) begin
                r_next.steps = '0;
                r_next.overflow = 1'b1;
            end else begin
                r_next.steps = r_reg.steps + 4'h1;
            end
        end else begin
            r_next.pre = r_reg.pre + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign overflow_o = r_reg.overflow;

endmodule : comm_watchdog

// ==== fault_monitor.sv ====
`timescale 1ns/1ps
module fault_monitor
    import fault_mon_pkg::*;
#(
    parameter int WDOG_CYCLES = WDOG_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    // Analog comparator indications, asynchronous
    input  wire logic              low_supply_below_i,
    input  wire logic              supply_uv_i,
    input  wire logic              ref_fault_i,
    input  wire logic              thermal_warn_i,
    input  wire logic              thermal_protect_i,
    input  wire logic              thermal_shutdown_i,
    input  wire logic [NUM_CH-1:0] open_detect_i,
    input  wire logic              failsafe_select_input_i,
    // Internal PWM state, same clock
    input  wire logic [NUM_CH-1:0] pwm_on_i,
    // Configuration, same clock
    input  wire logic [3:0]        blank_setting_i,
    input  wire logic [4:0]        low_supply_threshold_i,
    input  wire logic [3:0]        watchdog_period_field_i,
    // Frame results and commands, same clock
    input  wire logic              frame_ok_i,
    input  wire logic              frame_broadcast_i,
    input  wire logic              clear_reset_flag_cmd_i,
    input  wire logic              clear_fault_cmd_i,
    // Fault pin, open drain
    input  wire logic              fault_indicator_pin_n_i,
    output logic                   fault_indicator_pin_n_o,
    output logic                   fault_indicator_pin_n_oe_o,
    // Flags
    output logic                   reset_flag_o,
    output logic                   global_error_flag_o,
    output logic                   low_supply_flag_o,
    output logic                   supply_undervoltage_flag_o,
    output logic                   reference_fault_flag_o,
    output logic                   thermal_warning_flag_o,
    output logic                   thermal_protect_flag_o,
    output logic                   output_flag_o,
    output logic [NUM_CH-1:0]      channel_open_flag_o,
    // Actions
    output logic                   outputs_enable_o,
    output logic                   open_diag_enable_o,
    output logic                   sls_diag_enable_o,
    output logic                   device_reset_o,
    output logic                   failsafe_active_o,
    output logic                   failsafe_mode_o,
    output logic [5:0]             low_supply_threshold_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [SYN_W-1:0]                   sync1;
        logic [SYN_W-1:0]                   sync2;
        logic [SYN_W-1:0]                   prev;
        mon_state_t                         state;
        logic                               reset_flag;
        logic                               err_flag;
        logic                               lowvs_flag;
        logic                               uv_flag;
        logic                               ref_flag;
        logic                               twarn_flag;
        logic                               tprot_flag;
        logic                               out_flag;
        logic [NUM_CH-1:0]                  open_flag;
        logic [NUM_CH-1:0][BLANK_CNT_W-1:0] blank_cnt;
        logic                               pulse_trig;
        logic                               fault_drive;
        logic                               outputs_en;
        logic                               diag_en;
        logic                               fs_mode;
        logic                               dev_reset;
        logic [5:0]                         lowvs_volts;
    } mon_t;

    // Power-on image: reset and error flags come up set
    function automatic mon_t por_image();
        mon_t v;
        v = '0;
        v.state = ST_NORMAL;
        v.reset_flag = 1'b1;
        v.err_flag = 1'b1;
        v.lowvs_volts = LOW_SUPPLY_MIN_V;
        return v;
    endfunction : por_image

    mon_t r_reg;
    mon_t r_next;

    logic pulse_busy;
    logic wdog_overflow;
    logic wdog_kick;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pulse shortcuts the register stage so the pin follows the event by one cycle
    fault_pulse_timer u_pulse (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .trig_i    (r_reg.pulse_trig),
        .busy_o    (pulse_busy)
    );

    assign wdog_kick = frame_ok_i && !frame_broadcast_i;

    comm_watchdog #(
        .STEP_CYCLES (WDOG_CYCLES)
    ) u_wdog (
        .clk_sys_i               (clk_sys_i),
        .rstn_i                  (rstn_i),
        .run_i                   (r_reg.state == ST_NORMAL),
        .watchdog_period_field_i (watchdog_period_field_i),
        .kick_i                  (wdog_kick),
        .overflow_o              (wdog_overflow)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [SYN_W-1:0]       s;
        logic [SYN_W-1:0]       rise;
        logic [BLANK_CNT_W-1:0] lim;
        logic                   steady;
        logic                   any_open_evt;
        logic                   others;

        s = r_reg.sync2;
        rise = r_reg.sync2 & ~r_reg.prev;
        lim = blank_limit(blank_setting_i);
        steady = 1'b0;
        any_open_evt = 1'b0;
        others = 1'b0;

        r_next = r_reg;
        r_next.sync1 = {open_detect_i, failsafe_select_input_i, thermal_shutdown_i,
                        thermal_protect_i, thermal_warn_i, ref_fault_i, supply_uv_i,
                        low_supply_below_i};
        r_next.sync2 = r_reg.sync1;
        r_next.prev = r_reg.sync2;
        r_next.pulse_trig = 1'b0;
        r_next.lowvs_volts = 6'(low_supply_threshold_i) * LOW_SUPPLY_STEP_V
                           + LOW_SUPPLY_MIN_V;

        unique case (r_reg.state)
            ST_SHUTDOWN: begin
                // Regulator is off: outputs dead, pin held
                r_next.outputs_en = 1'b0;
                r_next.fault_drive = 1'b1;
                r_next.dev_reset = 1'b1;
                if (!s[SYN_TSD]) begin
                    r_next = por_image();
                    r_next.sync1 = r_reg.sync1;
                    r_next.sync2 = r_reg.sync1;
                    r_next.prev = r_reg.sync2;
                end
            end
            ST_NORMAL, ST_FAILSAFE: begin
                // Clears first so that a coincident event sets the flag again
                if (clear_fault_cmd_i) begin
                    r_next.err_flag = 1'b0;
                    r_next.lowvs_flag = 1'b0;
                    r_next.uv_flag = 1'b0;
                    r_next.ref_flag = 1'b0;
                    r_next.twarn_flag = 1'b0;
                    r_next.tprot_flag = 1'b0;
                    r_next.out_flag = 1'b0;
                    r_next.open_flag = '0;
                end
                if (clear_reset_flag_cmd_i) begin
                    r_next.reset_flag = 1'b0;
                    others = r_next.lowvs_flag | r_next.uv_flag | r_next.ref_flag
                           | r_next.twarn_flag | r_next.tprot_flag | r_next.out_flag;
                    if (!others) begin
                        r_next.err_flag = 1'b0;
                    end
                end

                if (s[SYN_LOWVS]) begin
                    r_next.lowvs_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                end
                if (rise[SYN_LOWVS]) begin
                    r_next.pulse_trig = 1'b1;
                end
                if (s[SYN_UV]) begin
                    r_next.uv_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                end
                if (s[SYN_REF]) begin
                    r_next.ref_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                end
                if (s[SYN_TWARN]) begin
                    r_next.twarn_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                end
                if (rise[SYN_TWARN]) begin
                    r_next.pulse_trig = 1'b1;
                end
                if (s[SYN_TPROT]) begin
                    r_next.tprot_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                end

                // Open monitor: counts only during PWM-on with supply good
                for (int ch = 0; ch < NUM_CH; ch++) begin
                    if (pwm_on_i[ch] && s[SYN_OPEN + ch] && !s[SYN_LOWVS]) begin
                        if (r_reg.blank_cnt[ch] < lim) begin
                            r_next.blank_cnt[ch] = r_reg.blank_cnt[ch] + 1'b1;
                        end
                        if (r_reg.blank_cnt[ch] == lim - 1'b1) begin
                            r_next.open_flag[ch] = 1'b1;
                            any_open_evt = 1'b1;
                        end else if (r_reg.blank_cnt[ch] >= lim) begin
                            r_next.open_flag[ch] = 1'b1;
                        end
                    end else begin
                        r_next.blank_cnt[ch] = '0;
                    end
                end
                if (any_open_evt) begin
                    r_next.pulse_trig = 1'b1;
                    r_next.out_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                end
                if (r_next.open_flag != '0 && r_reg.blank_cnt != '0) begin
                    r_next.out_flag = r_next.out_flag | any_open_evt;
                end

                // Only supply and temperature faults act on the outputs
                r_next.outputs_en = !s[SYN_UV] && !s[SYN_TPROT];
                r_next.diag_en = !s[SYN_LOWVS];
                steady = s[SYN_UV] | s[SYN_REF] | s[SYN_TPROT];
                r_next.fault_drive = steady | pulse_busy | r_reg.pulse_trig;
                r_next.dev_reset = 1'b0;

                if (r_reg.state == ST_NORMAL && wdog_overflow) begin
                    r_next.state = ST_FAILSAFE;
                    r_next.fs_mode = s[SYN_FSSEL];
                end
                if (s[SYN_TSD]) begin
                    r_next.state = ST_SHUTDOWN;
                    r_next.reset_flag = 1'b1;
                    r_next.err_flag = 1'b1;
                    r_next.outputs_en = 1'b0;
                    r_next.fault_drive = 1'b1;
                    r_next.dev_reset = 1'b1;
                end
            end
            default: begin
                r_next = por_image();
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_reg <= por_image();
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Pin only ever sinks; the fault_indicator_pin_n_i input is never read
    assign fault_indicator_pin_n_o    = ~r_reg.fault_drive;
    assign fault_indicator_pin_n_oe_o = r_reg.fault_drive;
    assign reset_flag_o               = r_reg.reset_flag;
    assign global_error_flag_o        = r_reg.err_flag;
    assign low_supply_flag_o          = r_reg.lowvs_flag;
    assign supply_undervoltage_flag_o = r_reg.uv_flag;
    assign reference_fault_flag_o     = r_reg.ref_flag;
    assign thermal_warning_flag_o     = r_reg.twarn_flag;
    assign thermal_protect_flag_o     = r_reg.tprot_flag;
    assign output_flag_o              = r_reg.out_flag;
    assign channel_open_flag_o        = r_reg.open_flag;
    assign outputs_enable_o           = r_reg.outputs_en;
    assign open_diag_enable_o         = r_reg.diag_en;
    assign sls_diag_enable_o          = r_reg.diag_en;
    assign device_reset_o             = r_reg.dev_reset;
    assign failsafe_active_o          = (r_reg.state == ST_FAILSAFE);
    assign failsafe_mode_o            = r_reg.fs_mode;
    assign low_supply_threshold_o     = r_reg.lowvs_volts;

endmodule : fault_monitor

// ==== fault_monitor_sva.sv ====
`timescale 1ns/1ps
module fault_monitor_sva #(
    parameter int WDOG_CYCLES = 8
) (
    // Clock, reset, causes
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic low_supply_below_i,
    input wire logic supply_uv_i,
    input wire logic thermal_protect_i,
    input wire logic thermal_shutdown_i,
    input wire logic clear_fault_cmd_i,
    // Pin, flags, actions
    input wire logic fault_indicator_pin_n_o,
    input wire logic fault_indicator_pin_n_oe_o,
    input wire logic reset_flag_o,
    input wire logic global_error_flag_o,
    input wire logic low_supply_flag_o,
    input wire logic supply_undervoltage_flag_o,
    input wire logic thermal_protect_flag_o,
    input wire logic outputs_enable_o,
    input wire logic device_reset_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_sink8;
        fault_indicator_pin_n_oe_o [*8];
    endsequence
    // Cooling seen past the two sync flops
    sequence s_cool;
        $fell(thermal_protect_i) ##1 (!thermal_protect_i && !supply_uv_i) [*5];
    endsequence
    property p_pin;
        fault_indicator_pin_n_oe_o |-> !fault_indicator_pin_n_o;
    endproperty
    property p_low_pulse;
        $rose(low_supply_below_i) |-> ##[3:5] s_sink8;
    endproperty
    property p_low_flag;
        low_supply_below_i [*5] |-> low_supply_flag_o && global_error_flag_o && outputs_enable_o;
    endproperty
    property p_uv;
        supply_uv_i [*5] |-> supply_undervoltage_flag_o && !outputs_enable_o
            && fault_indicator_pin_n_oe_o;
    endproperty
    property p_tprot;
        thermal_protect_i [*5] |-> thermal_protect_flag_o && !outputs_enable_o
            && fault_indicator_pin_n_oe_o;
    endproperty
    property p_tprot_off;
        s_cool |-> outputs_enable_o && thermal_protect_flag_o && !fault_indicator_pin_n_oe_o;
    endproperty
    property p_tsd;
        thermal_shutdown_i [*5] |-> device_reset_o && reset_flag_o && global_error_flag_o
            && fault_indicator_pin_n_oe_o;
    endproperty
    property p_clear;
        (!low_supply_below_i && !supply_uv_i && !thermal_protect_i) [*6] ##0 clear_fault_cmd_i
            |=> !low_supply_flag_o && !supply_undervoltage_flag_o && !thermal_protect_flag_o;
    endproperty
    a_pin:       assert property (p_pin) else $error("pin driven high while enabled");
    a_low_pulse: assert property (p_low_pulse) else $error("low supply pulse short");
    a_low_flag:  assert property (p_low_flag) else $error("low supply flag wrong");
    a_uv:        assert property (p_uv) else $error("undervoltage reaction wrong");
    a_tprot:     assert property (p_tprot) else $error("overtemp reaction wrong");
    a_tprot_off: assert property (p_tprot_off) else $error("overtemp recovery wrong");
    a_tsd:       assert property (p_tsd) else $error("shutdown reaction wrong");
    a_clear:     assert property (p_clear) else $error("clear fault ignored");
endmodule : fault_monitor_sva

bind fault_monitor fault_monitor_sva #(.WDOG_CYCLES(WDOG_CYCLES)) u_sva (.clk_sys_i, .rstn_i,
    .low_supply_below_i, .supply_uv_i, .thermal_protect_i, .thermal_shutdown_i,
    .clear_fault_cmd_i, .fault_indicator_pin_n_o, .fault_indicator_pin_n_oe_o, .reset_flag_o,
    .global_error_flag_o, .low_supply_flag_o, .supply_undervoltage_flag_o,
    .thermal_protect_flag_o, .outputs_enable_o, .device_reset_o);

// ==== master_ctrl_model.sv ====
`timescale 1ns/1ps
module master_ctrl_model (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // Bench requests and live conditions
    input  wire logic       fault_req_i,
    input  wire logic       reset_req_i,
    input  wire logic [5:0] cond_i,
    // One-cycle clear commands
    output logic            clear_fault_cmd_o,
    output logic            clear_reset_flag_cmd_o
);
    // Clearing while a condition stands would only re-latch it
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clear_fault_cmd_o      <= 1'b0;
            clear_reset_flag_cmd_o <= 1'b0;
        end else begin
            clear_fault_cmd_o      <= fault_req_i && !clear_fault_cmd_o && cond_i == 6'h00;
            clear_reset_flag_cmd_o <= reset_req_i && !clear_reset_flag_cmd_o && cond_i == 6'h00;
        end
    end
endmodule : master_ctrl_model

// ==== tb_normal_state_fault_monitor.sv ====
`timescale 1ns/1ps
module tb_normal_state_fault_monitor;
    import fault_mon_pkg::*;
    logic              clk_sys_i, rstn_i, fs_sel, fok, bc, rq_f, rq_r, cf, cr, pin_o, oe, pin;
    logic              rf, ef, of, ena, dg, sl, dr, fa, fm;
    logic [5:0]        cond, thr_o;
    logic [4:0]        flags, thr;
    logic [3:0]        blank, wdf;
    logic [NUM_CH-1:0] opn, pwm, chf;
    int                err_count = 0, checks_done = 0, seed = 32'h0000_a155, n, ch;
    assign pin = oe ? pin_o : 1'b1;
    fault_monitor #(.WDOG_CYCLES(8)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .low_supply_below_i(cond[0]), .supply_uv_i(cond[1]), .ref_fault_i(cond[2]),
        .thermal_warn_i(cond[3]), .thermal_protect_i(cond[4]), .thermal_shutdown_i(cond[5]),
        .open_detect_i(opn), .failsafe_select_input_i(fs_sel), .pwm_on_i(pwm),
        .blank_setting_i(blank), .low_supply_threshold_i(thr), .watchdog_period_field_i(wdf),
        .frame_ok_i(fok), .frame_broadcast_i(bc), .clear_reset_flag_cmd_i(cr),
        .clear_fault_cmd_i(cf), .fault_indicator_pin_n_i(pin), .fault_indicator_pin_n_o(pin_o),
        .fault_indicator_pin_n_oe_o(oe), .reset_flag_o(rf), .global_error_flag_o(ef),
        .low_supply_flag_o(flags[0]), .supply_undervoltage_flag_o(flags[1]),
        .reference_fault_flag_o(flags[2]), .thermal_warning_flag_o(flags[3]),
        .thermal_protect_flag_o(flags[4]), .output_flag_o(of), .channel_open_flag_o(chf),
        .outputs_enable_o(ena), .open_diag_enable_o(dg), .sls_diag_enable_o(sl),
        .device_reset_o(dr), .failsafe_active_o(fa), .failsafe_mode_o(fm),
        .low_supply_threshold_o(thr_o));
    master_ctrl_model u_master (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .fault_req_i(rq_f),
        .reset_req_i(rq_r), .cond_i(cond), .clear_fault_cmd_o(cf), .clear_reset_flag_cmd_o(cr));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask : tick
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic clr(input logic r);
        rq_r <= r;
        rq_f <= !r;
        for (int k = 0; k < 2000 && !(r ? cr : cf); k++) tick(1);
        rq_r <= 1'b0;
        rq_f <= 1'b0;
        tick(2);
    endtask : clr
    task automatic kicks(input int k);
        repeat (k) begin
            tick(10);
            fok <= 1'b1;
            tick(1);
            fok <= 1'b0;
        end
    endtask : kicks
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #(10000 * 100);
        err_count++;
        test_done();
    end
    initial begin
        {rstn_i, fs_sel, fok, bc, rq_f, rq_r, cond, thr, blank, wdf, opn, pwm} = '0;
        tick(16);
        rstn_i <= 1'b1;
        tick(4);
        chk("power_on", {rf, ef, flags, of, chf, thr_o}, {2'b11, 36'd4});
        clr(1'b1);
        chk("reset_err", {rf, ef}, 0);
        for (int i = 0; i < 8; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 31 : $unsigned($random(seed)) % 32;
            thr <= 5'(n);
            tick(3);
            chk("threshold", thr_o, n + 4);
        end
        $display("Test reset and threshold done");
        // Each fault alone; the loop counts pin-sink cycles while it stands
        for (int i = 0; i < 5; i++) begin
            cond[i] <= 1'b1;
            n = 0;
            repeat (700) begin
                tick(1);
                n += int'(oe === 1'b1);
            end
            chk("flags", {flags, ef}, {5'(1 << i), 1'b1});
            chk("outputs_on", ena, (i == 1 || i == 4) ? 0 : 1);
            chk("diag_on", {dg, sl}, (i == 0) ? 0 : 3);
            chk("sink_len", (i == 0 || i == 3) ? n inside {[PULSE_CYCLES:PULSE_CYCLES + 1]}
                : n > 690, 1);
            cond[i] <= 1'b0;
            tick(10);
            chk("recovered", {oe, ena, dg, sl, flags}, {4'b0111, 5'(1 << i)});
            clr(1'b0);
            chk("cleared", {flags, ef}, 0);
        end
        $display("Test fault table done");
        cond[5] <= 1'b1;
        tick(8);
        chk("shutdown", {dr, rf, ef, oe}, 4'hF);
        cond[5] <= 1'b0;
        tick(10);
        chk("restart", {dr, oe, rf, ef}, 4'h3);
        clr(1'b1);
        chk("reset_err", {rf, ef}, 0);
        $display("Test shutdown done");
        ch = $unsigned($random(seed)) % NUM_CH;
        pwm <= '1;
        opn[ch] <= 1'b1;
        tick(30);
        chk("open", {chf, of, ef}, {NUM_CH'(1) << ch, 2'b11});
        opn <= '0;
        tick(10);
        clr(1'b0);
        pwm <= '0;
        opn <= '1;
        tick(40);
        chk("open_pwm_off", chf, 0);
        pwm <= '1;
        cond[0] <= 1'b1;
        tick(40);
        chk("open_low_supply", chf, 0);
        opn <= '0;
        cond[0] <= 1'b0;
        $display("Test open done");
        fs_sel <= 1'($random(seed));
        wdf <= 4'h2;
        kicks(6);
        chk("failsafe", fa, 0);
        bc <= 1'b1;
        kicks(3);
        chk("failsafe", {fa, fm}, {1'b1, fs_sel});
        rstn_i <= 1'b0;
        wdf <= 4'h0;
        tick(2);
        rstn_i <= 1'b1;
        tick(60);
        chk("failsafe_off", fa, 0);
        wdf <= 4'hF;
        tick(8);
        chk("failsafe_direct", fa, 1);
        $display("Test watchdog done");
        test_done();
    end
endmodule : tb_normal_state_fault_monitor
